// >>> lms_defines.svh
// constants for the listen mode sequencer and its host end
// Function
// [R1] idle keeps only rc oscillator running
// [R2] periodic receive, keep on when found
// [R3] interrupt host on packet received
// [R4] preamble found: sequencer off, stay receive
// [R5] cycle every t1+t2, receive for t2
// [R6] preamble flag on pin four, code 11
// [R7] host programs wake-on-preamble selector values
// [R8] second interval bounds receive without preamble
// [R9] t1 plus t2 sets cycling period
// [R10] host: short t2, long t1
// [R11] transmitter preamble at least t1+2*t2
// [R12] wake-on-sync: preamble then sync match
// [R13] wake lasts rx window, else low power
// [R14] preamble before window end: keep receiving
// [R15] no sync by t2 end: resume polling
// [R16] sync match: flag, sequencer off, receive
// [R17] host programs exit 101 and expiry 10
// [R18] host sets first interval 64 us
// [R19] timers count on rc clock during sleep
// [R20] off sequencer holds mode until host acts
`ifndef LMS_DEFINES_SVH
`define LMS_DEFINES_SVH
`define LMS_TIMER_W          16
`define LMS_START_TO_LP      2'h0
`define LMS_LP_TO_IDLE       1'h1
`define LMS_IDLE_TO_RX       1'h1
`define LMS_IDLE_DEPTH_SLEEP 1'h1
`define LMS_RX_OFF_ON_PRE    3'h6
`define LMS_RX_OFF_ON_SYNC   3'h5
`define LMS_EXPIRY_TO_LP     2'h2
`define LMS_PIN4_PRE_MAP     2'h3
`define LMS_T1_MIN_US        64
`define LMS_CLK_MHZ          100
`define LMS_T1_MIN_CYC       (`LMS_T1_MIN_US * `LMS_CLK_MHZ)
`define LMS_REG_CTRL         4'h0
`define LMS_REG_SEL          4'h1
`define LMS_REG_T1           4'h2
`define LMS_REG_T2           4'h3
`define LMS_REG_RXTO         4'h4
`define LMS_REG_STATUS       4'h5
`endif

// >>> lms_device.sv
// listen mode sequencer, device end
`timescale 1ns/1ps
`include "lms_defines.svh"
module lms_device (
    input  wire logic clk,
    input  wire logic arst_n,
    lms_if.dev        lk,
    input  wire logic preamble_found_flag,
    input  wire logic sync_match_flag,
    input  wire logic payload_complete_flag,
    output logic      sync_event,
    output logic      payload_event
);
    lms_pkg::lms_state_t state_reg;
    lms_pkg::lms_state_t lp_next;
    logic [16:0] cnt_reg;
    logic [16:0] period_end;
    logic        pre_seen_reg;
    logic        pre_pin_reg;
    logic        irq_reg;
    logic        sync_ev_reg;
    logic        pay_ev_reg;
    logic        sync_mode;
    logic        t1_done;
    logic        t2_done;
    logic        win_done;

    assign sync_mode  = (lk.receive_exit_select == `LMS_RX_OFF_ON_SYNC);
    // one counter spans receive and the idle after it, so the idle
    // stretch is whatever is left of the t1+t2 period
    assign period_end = {1'b0, lk.first_interval} + {1'b0, lk.second_interval};
    assign t1_done    = (cnt_reg + 17'h00001 >= period_end);
    assign t2_done    = (cnt_reg + 17'h00001 >= {1'b0, lk.second_interval});
    assign win_done   = (cnt_reg + 17'h00001 >= {1'b0, lk.rx_window});
    // a low power target other than idle parks the sequencer
    assign lp_next    = (lk.low_power_target_select == `LMS_LP_TO_IDLE) ?
                        lms_pkg::LMS_IDLE : lms_pkg::LMS_OFF;

    // timers keep running in sleep; only the rc clock is assumed live
    // outside the cycle, preload t2 so the first idle lasts t1
    always_ff @(posedge clk or negedge arst_n) begin // [R19]
        if (!arst_n)
            cnt_reg <= 17'h00000;
        else if (state_reg == lms_pkg::LMS_IDLE)
            cnt_reg <= t1_done ? 17'h00000 : cnt_reg + 17'h00001;
        else if (state_reg == lms_pkg::LMS_RX)
            cnt_reg <= cnt_reg + 17'h00001;
        else
            cnt_reg <= {1'b0, lk.second_interval};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= lms_pkg::LMS_OFF;
            pre_seen_reg <= 1'b0;
        end else if (lk.seq_stop || lk.mode_write) begin
            state_reg    <= lms_pkg::LMS_OFF; // [R20]
            pre_seen_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                lms_pkg::LMS_OFF:
                    if (lk.seq_start)
                        state_reg <= lms_pkg::LMS_START;
                lms_pkg::LMS_START:
                    if (lk.start_transition_select == `LMS_START_TO_LP)
                        state_reg <= lp_next;
                    else
                        state_reg <= lms_pkg::LMS_RX;
                lms_pkg::LMS_IDLE: begin
                    pre_seen_reg <= 1'b0;
                    // rest of the t1+t2 period elapsed: enter receive
                    if (t1_done &&
                        lk.idle_exit_select == `LMS_IDLE_TO_RX) // [R2] [R5] [R9]
                        state_reg <= lms_pkg::LMS_RX;
                end
                lms_pkg::LMS_RX: begin
                    if (preamble_found_flag)
                        pre_seen_reg <= 1'b1;
                    if (!sync_mode && preamble_found_flag)
                        state_reg <= lms_pkg::LMS_HOLD_RX; // [R4]
                    else if (sync_mode && sync_match_flag &&
                             (pre_seen_reg || preamble_found_flag))
                        state_reg <= lms_pkg::LMS_HOLD_RX; // [R12] [R16]
                    else if (sync_mode && win_done && !pre_seen_reg &&
                             !preamble_found_flag &&
                             lk.rx_window_expiry_select == `LMS_EXPIRY_TO_LP)
                        state_reg <= lms_pkg::LMS_IDLE; // [R13] [R14]
                    else if (t2_done)
                        state_reg <= lms_pkg::LMS_IDLE; // [R8] [R15] [R5]
                end
                lms_pkg::LMS_HOLD_RX:
                    if (lk.seq_start)
                        state_reg <= lms_pkg::LMS_START; // [R20]
                default:
                    state_reg <= lms_pkg::LMS_OFF;
            endcase
        end
    end

    // pin four carries the preamble flag only with code 11 and route enable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            pre_pin_reg <= 1'b0;
        else
            pre_pin_reg <= preamble_found_flag && lk.preamble_flag_route_enable &&
                           lk.pin_four_map == `LMS_PIN4_PRE_MAP; // [R6]
    end

    // receive-only events: any time the receiver is on
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_reg     <= 1'b0;
            sync_ev_reg <= 1'b0;
            pay_ev_reg  <= 1'b0;
        end else begin
            pay_ev_reg  <= payload_complete_flag && lk.rx_on;
            sync_ev_reg <= sync_match_flag && lk.rx_on;
            irq_reg     <= payload_complete_flag && lk.rx_on; // [R3]
        end
    end

    assign lk.digital_io_pin_four = pre_pin_reg;
    assign lk.irq                 = irq_reg;
    assign lk.rx_on       = (state_reg == lms_pkg::LMS_RX) || (state_reg == lms_pkg::LMS_HOLD_RX);
    assign lk.rc_only     = (state_reg == lms_pkg::LMS_IDLE) &&
                            (lk.idle_depth_select == `LMS_IDLE_DEPTH_SLEEP); // [R1]
    assign lk.seq_running = (state_reg != lms_pkg::LMS_OFF) &&
                            (state_reg != lms_pkg::LMS_HOLD_RX);
    assign sync_event     = sync_ev_reg;
    assign payload_event  = pay_ev_reg;
endmodule : lms_device

// >>> lms_host.sv
// host controller end: registers of its own, drives the sequencer link
`timescale 1ns/1ps
`include "lms_defines.svh"
module lms_host (
    input  wire logic        clk,
    input  wire logic        arst_n,
    lms_if.host              lk,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata
);
    logic [1:0]  ctrl_reg;
    logic [12:0] sel_reg;
    logic [15:0] t1_reg;
    logic [15:0] t2_reg;
    logic [15:0] rxto_reg;
    logic [31:0] rdata_reg;
    logic        irq_sticky_reg;
    logic        mode_reg;

    // ctrl: bit0 start pulse, bit1 stop pulse; sel write also acts as mode change
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= 2'h0;
            mode_reg <= 1'b0;
            sel_reg  <= {`LMS_PIN4_PRE_MAP, 1'b1, `LMS_EXPIRY_TO_LP,
                         `LMS_RX_OFF_ON_PRE, `LMS_IDLE_TO_RX, `LMS_LP_TO_IDLE,
                         `LMS_START_TO_LP, `LMS_IDLE_DEPTH_SLEEP}; // [R7] [R17]
            t1_reg   <= 16'(`LMS_T1_MIN_CYC); // [R18]
            t2_reg   <= 16'h0100; // [R10]
            rxto_reg <= 16'h0040;
        end else begin
            ctrl_reg <= (wr && addr == `LMS_REG_CTRL) ? wdata[1:0] : 2'h0;
            mode_reg <= wr && addr == `LMS_REG_SEL; // [R20]
            if (wr && addr == `LMS_REG_SEL)
                sel_reg <= wdata[12:0];
            if (wr && addr == `LMS_REG_T1)
                t1_reg <= wdata[15:0];
            if (wr && addr == `LMS_REG_T2)
                t2_reg <= wdata[15:0];
            if (wr && addr == `LMS_REG_RXTO)
                rxto_reg <= wdata[15:0];
        end
    end

    // sticky irq, set wins over a clearing write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            irq_sticky_reg <= 1'b0;
        else if (lk.irq)
            irq_sticky_reg <= 1'b1;
        else if (wr && addr == `LMS_REG_STATUS && wdata[0])
            irq_sticky_reg <= 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            rdata_reg <= 32'h0000_0000;
        else if (rd) begin
            unique case (addr)
                `LMS_REG_SEL:    rdata_reg <= {19'h0, sel_reg};
                `LMS_REG_T1:     rdata_reg <= {16'h0, t1_reg};
                `LMS_REG_T2:     rdata_reg <= {16'h0, t2_reg};
                `LMS_REG_RXTO:   rdata_reg <= {16'h0, rxto_reg};
                `LMS_REG_STATUS: rdata_reg <= {27'h0, lk.digital_io_pin_four, lk.seq_running,
                                               lk.rc_only, lk.rx_on, irq_sticky_reg};
                default:         rdata_reg <= 32'h0000_0000;
            endcase
        end else
            rdata_reg <= 32'h0000_0000;
    end

    assign rdata                         = rdata_reg;
    assign lk.seq_start                  = ctrl_reg[0];
    assign lk.seq_stop                   = ctrl_reg[1];
    assign lk.mode_write                 = mode_reg;
    assign lk.idle_depth_select          = sel_reg[0];
    assign lk.start_transition_select    = sel_reg[2:1];
    assign lk.low_power_target_select    = sel_reg[3];
    assign lk.idle_exit_select           = sel_reg[4];
    assign lk.receive_exit_select        = sel_reg[7:5];
    assign lk.rx_window_expiry_select    = sel_reg[9:8];
    assign lk.preamble_flag_route_enable = sel_reg[10];
    assign lk.pin_four_map               = sel_reg[12:11];
    assign lk.first_interval             = t1_reg;
    assign lk.second_interval            = t2_reg;
    assign lk.rx_window                  = rxto_reg;
endmodule : lms_host

// >>> lms_if.sv
// link between host controller and listen mode sequencer
`timescale 1ns/1ps
interface lms_if;
    logic        seq_start;
    logic        seq_stop;
    logic        mode_write;
    logic        idle_depth_select;
    logic [1:0]  start_transition_select;
    logic        low_power_target_select;
    logic        idle_exit_select;
    logic [2:0]  receive_exit_select;
    logic [1:0]  rx_window_expiry_select;
    logic        preamble_flag_route_enable;
    logic [1:0]  pin_four_map;
    logic [15:0] first_interval;
    logic [15:0] second_interval;
    logic [15:0] rx_window;
    logic        digital_io_pin_four;
    logic        irq;
    logic        rx_on;
    logic        rc_only;
    logic        seq_running;
    modport dev (input seq_start, seq_stop, mode_write, idle_depth_select,
                 start_transition_select, low_power_target_select, idle_exit_select,
                 receive_exit_select, rx_window_expiry_select,
                 preamble_flag_route_enable, pin_four_map, first_interval,
                 second_interval, rx_window,
                 output digital_io_pin_four, irq, rx_on, rc_only, seq_running);
    modport host (output seq_start, seq_stop, mode_write, idle_depth_select,
                  start_transition_select, low_power_target_select, idle_exit_select,
                  receive_exit_select, rx_window_expiry_select,
                  preamble_flag_route_enable, pin_four_map, first_interval,
                  second_interval, rx_window,
                  input digital_io_pin_four, irq, rx_on, rc_only, seq_running);
endinterface : lms_if

// >>> lms_monitor.sv
// assertions on the link between host and listen mode sequencer
`timescale 1ns/1ps
module lms_monitor (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        seq_start,
    input wire logic        seq_stop,
    input wire logic        mode_write,
    input wire logic [15:0] first_interval,
    input wire logic [15:0] second_interval,
    input wire logic        preamble_flag_route_enable,
    input wire logic [1:0]  pin_four_map,
    input wire logic        digital_io_pin_four,
    input wire logic        irq,
    input wire logic        rx_on,
    input wire logic        rc_only,
    input wire logic        seq_running
);
    logic [16:0] rx_cnt_reg;
    logic [16:0] lp_cnt_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // run lengths of receive and sleep, too long for a repetition
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_cnt_reg <= 17'h0;
            lp_cnt_reg <= 17'h0;
        end else begin
            rx_cnt_reg <= (rx_on && seq_running) ? rx_cnt_reg + 17'h1 : 17'h0;
            lp_cnt_reg <= rc_only ? lp_cnt_reg + 17'h1 : 17'h0;
        end
    end
    chk_idle_no_rx: assert property (rc_only |-> !rx_on)
        else $error("receiver on while idle");
    chk_start_idle: assert property (
        seq_start && !seq_running && !rx_on |-> ##[1:3] (seq_running && rc_only))
        else $error("no idle after start");
    chk_stop_off: assert property (seq_stop |-> ##[1:2] (!seq_running && !rx_on))
        else $error("stop did not switch off");
    chk_hold_keeps: assert property (
        !seq_running && rx_on && !seq_stop && !mode_write && !seq_start
        |=> rx_on && !seq_running)
        else $error("held receive changed");
    chk_rx_bound: assert property (rx_cnt_reg <= {1'h0, second_interval} + 17'h2)
        else $error("receive window too long");
    chk_period_bound: assert property (
        lp_cnt_reg <= {1'h0, first_interval} + {1'h0, second_interval} + 17'h2)
        else $error("sleep too long");
    chk_leave_rx: assert property (
        (seq_running && rx_on && !seq_stop && !mode_write) ##1 !seq_running |-> rx_on)
        else $error("receiver dropped on wake");
    chk_pin4_route: assert property ($rose(digital_io_pin_four) |->
        $past(preamble_flag_route_enable) && $past(pin_four_map) == 2'h3)
        else $error("pin four raised without route");
    chk_mode_off: assert property (mode_write |=> !seq_running && !rx_on)
        else $error("mode write did not switch off");
    chk_irq_rx: assert property (irq |-> $past(rx_on))
        else $error("interrupt outside receive");
    cover property (seq_start);
    cover property ($fell(seq_running) && rx_on);
    cover property (irq);
    cover property (mode_write);
endmodule : lms_monitor

// >>> lms_pkg.sv
// types for the listen mode sequencer
package lms_pkg;
    typedef enum logic [2:0] {
        LMS_OFF, LMS_START, LMS_IDLE, LMS_RX, LMS_HOLD_RX
    } lms_state_t;
endpackage : lms_pkg

// >>> tb.sv
// self-checking bench: host and sequencer joined on one link
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    logic        clk;
    logic        arst_n;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        pre;
    logic        syn;
    logic        pay;
    logic        sync_event;
    logic        payload_event;
    logic        saw_sync;
    logic        saw_pay;
    logic [31:0] rs;
    logic [31:0] v;
    logic [15:0] t1;
    logic [15:0] t2;
    int          fail_count;
    int          n_compared;
    int          n;
    int          gap;
    lms_if lk ();
    lms_host lms_host_inst (.clk(clk), .arst_n(arst_n), .lk(lk.host), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    lms_device lms_device_inst (.clk(clk), .arst_n(arst_n), .lk(lk.dev),
        .preamble_found_flag(pre), .sync_match_flag(syn), .payload_complete_flag(pay),
        .sync_event(sync_event), .payload_event(payload_event));
    lms_monitor mon (.clk(clk), .arst_n(arst_n), .seq_start(lk.seq_start),
        .seq_stop(lk.seq_stop), .mode_write(lk.mode_write), .first_interval(lk.first_interval),
        .second_interval(lk.second_interval), .pin_four_map(lk.pin_four_map),
        .preamble_flag_route_enable(lk.preamble_flag_route_enable), .irq(lk.irq),
        .digital_io_pin_four(lk.digital_io_pin_four), .rx_on(lk.rx_on),
        .rc_only(lk.rc_only), .seq_running(lk.seq_running));
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs
    // selector word: sleep idle, start to low power, idle on, chosen exit
    function automatic logic [31:0] sel_word(input logic [2:0] rx_exit);
        return {19'h0, 2'h3, 1'h1, 2'h2, rx_exit, 1'h1, 1'h1, 2'h0, 1'h1};
    endfunction : sel_word
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wreg
    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        d = rdata;
    endtask : rreg
    task automatic wrx(output int g);
        g = 0;
        while (lk.rx_on !== 1'h1 && g < 5000) begin
            @(negedge clk);
            g++;
        end
    endtask : wrx
    // gap before a receive window and its length, both in cycles
    task automatic span(output int g, output int d);
        wrx(g);
        d = 0;
        while (lk.rx_on === 1'h1 && d < 5000) begin
            @(negedge clk);
            d++;
        end
    endtask : span
    task automatic summarize();
        $display("compared=%0d failed=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (sync_event === 1'h1) saw_sync <= 1'h1;
    always @(posedge clk) if (payload_event === 1'h1) saw_pay <= 1'h1;
    // whole run is a few hundred cycles
    initial begin
        #500000;
        fail_count++;
        summarize();
    end
    initial begin
        {arst_n, addr, wdata, wr, rd, pre, syn, pay, saw_sync, saw_pay} = '0;
        rs = 32'h3D;
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;
        rreg(4'h1, v);
        `CHK(v, sel_word(3'h6))
        rreg(4'hF, v);
        `CHK(v, 32'h0)
        v = xs();
        t1 = 16'h10 + v[4:0];
        v = xs();
        t2 = 16'h10 + v[4:0];
        wreg(4'h2, {16'h0, t1});
        wreg(4'h3, {16'h0, t2});
        wreg(4'h4, 32'h8);
        wreg(4'h0, 32'h1);
        span(gap, n);
        span(gap, n);
        `CHK(n >= t2 && n <= t2 + 2, 1'h1)
        `CHK(gap >= t1 && gap <= t1 + 2, 1'h1)
        wrx(gap);
        @(posedge clk);
        pre <= 1'h1;
        repeat (3) @(negedge clk);
        `CHK({lk.seq_running, lk.rx_on, lk.digital_io_pin_four}, 3'h3)
        repeat (40) @(negedge clk);
        `CHK(lk.rx_on, 1'h1)
        @(posedge clk);
        pay <= 1'h1;
        @(posedge clk);
        pay <= 1'h0;
        pre <= 1'h0;
        rreg(4'h5, v);
        `CHK(v[0], 1'h1)
        `CHK(saw_pay, 1'h1)
        wreg(4'h5, 32'h1);
        rreg(4'h5, v);
        `CHK(v[0], 1'h0)
        wreg(4'h0, 32'h2);
        wreg(4'h1, sel_word(3'h5));
        wreg(4'h0, 32'h1);
        span(gap, n);
        `CHK(n >= 8 && n <= 10, 1'h1)
        @(posedge clk);
        pre <= 1'h1;
        span(gap, n);
        `CHK(n >= t2 && n <= t2 + 2, 1'h1)
        `CHK(gap >= t1 + t2 - 8 && gap <= t1 + t2 - 6, 1'h1)
        wrx(gap);
        @(posedge clk);
        syn <= 1'h1;
        repeat (4) @(negedge clk);
        `CHK({saw_sync, lk.seq_running, lk.rx_on}, 3'h5)
        wreg(4'h0, 32'h2);
        summarize();
    end
endmodule : tb
